// >>> rtie_top.v
// Interrupt enable register and interrupt output gating of the remote terminal
`include "rtie_map.vh"
`default_nettype none

// Contract
// RL1 - Master reset release loads enable 0x0007
// RL2 - Software reset leaves enable untouched
// RL3 - Low three bits read one, ignore writes
// RL4 - Cleared enable bit blocks its output
// RL5 - Late enable never fires earlier events
// RL6 - Index zero or circular count: message output
// RL7 - Accessed subaddress raises message output
// RL8 - Broadcast received raises message output
// RL9 - Message error flag raises message output
// RL10 - Table bit one marks illegal command
// RL11 - Illegal command: error flag, no data
// RL12 - Host serial clock count fault: hardware
// RL13 - Loopback word mismatch per bus: message
// RL14 - Time tag equals utility: hardware output
// RL15 - Time tag wrap raises hardware output
// RL16 - Address parity error raises hardware output
// RL17 - Init checksum failure raises hardware output
// RL18 - RAM init mismatch raises hardware output
// RL19 - Descriptor bit clear: nothing happens
// RL20 - Descriptor types need both bits set
// RL21 - Other types always pend, output if enabled
// RL22 - Log type word and source address
module rtie_top #(
  parameter SER_CNT_W = 16
) (
  input wire ref_clk,
  input wire rst,
  input wire masterResetN,
  input wire softResetCmd,
  input wire [15:0] hostAddr,
  input wire hostWrEn,
  input wire hostRdEn,
  input wire [15:0] hostWrData,
  output reg [15:0] hostRdData,
  input wire [15:0] descAddr,
  input wire descIndexZeroEn,
  input wire descAccessedEn,
  input wire descBroadcastEn,
  input wire indexDecToZero,
  input wire circCountReached,
  input wire msgAccess,
  input wire msgBroadcast,
  input wire msgErrorDetect,
  input wire cmdValid,
  input wire illegalTableBit,
  input wire hostSerialSelN,
  input wire hostSerialClk,
  input wire txWordValid,
  input wire txBusB,
  input wire [15:0] txWord,
  input wire rxWordValid,
  input wire [15:0] rxWord,
  input wire [15:0] timeTagCount,
  input wire [15:0] timeTagUtility,
  input wire [4:0] termAddr,
  input wire termAddrParity,
  input wire initChecksumFail,
  input wire ramInitFail,
  output reg messageIrqOut,
  output reg hardwareIrqOut,
  output reg [15:0] pendingSet,
  output reg logWrite,
  output reg [15:0] irqTypeWord,
  output reg [15:0] irqSourceWord,
  output reg messageErrorFlag,
  output reg dataWordsInhibit
);

  // ****************************************
  // Functions
  // ****************************************
  // Odd parity over address and parity pin
  function parityBad;
    input [4:0] addr;
    input par;
    begin
      parityBad = ~(^{addr, par});
    end
  endfunction

  function regHit;
    input [15:0] addr;
    begin
      regHit = (addr == `RTIE_IE_OFS);
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  reg [15:0] irqEnable;
  reg mrPrev;
  reg [15:0] ttPrev;
  reg ttSeen;
  reg parPrev;
  reg selPrev;
  reg sclkPrev;
  reg [SER_CNT_W-1:0] serCount;
  reg serFail;
  reg lbPending;
  reg lbBusB;
  reg [15:0] lbWord;
  reg lbFailA;
  reg lbFailB;
  reg ttMatch;
  reg ttWrap;
  reg parFail;
  wire mrRise;
  wire illegalCmd;
  wire parNow;
  wire [15:0] evtVec;
  wire [15:0] descBits;
  wire [15:0] pendNow;
  wire [15:0] fireNow;
  wire anyMsgFire;
  wire serEnd;
  wire serBad;
  wire lbMismatch;
  wire lbMissed;

  // ****************************************
  // Master reset edge
  // ****************************************
  assign mrRise = masterResetN & ~mrPrev;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mrPrev <= 1'b1;
    end else begin
      mrPrev <= masterResetN;
    end
  end

  // ****************************************
  // Interrupt enable register
  // ****************************************
  // Soft reset deliberately absent here
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqEnable <= `RTIE_IE_RST;
    end else if (!masterResetN || mrRise) begin
      // RL1 master reset load
      irqEnable <= `RTIE_IE_RST;
    end else if (hostWrEn && regHit(hostAddr)) begin
      // RL3 low bits stay one
      irqEnable <= (hostWrData & `RTIE_IE_WMASK) | `RTIE_IE_ROONE;
    end
  end
  // RL2 soft reset ignored by enable

  // ****************************************
  // Host read path
  // ****************************************
  // Unmapped addresses read zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostRdData <= 16'h0000;
    end else if (hostRdEn) begin
      hostRdData <= regHit(hostAddr) ? irqEnable : 16'h0000;
    end
  end

  // ****************************************
  // Illegal command and status flags
  // ****************************************
  // RL10 table bit decides
  assign illegalCmd = cmdValid & illegalTableBit;

  // Set wins over soft reset and a new command
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      messageErrorFlag <= 1'b0;
      dataWordsInhibit <= 1'b0;
    end else if (softResetCmd) begin
      messageErrorFlag <= illegalCmd | msgErrorDetect;
      dataWordsInhibit <= illegalCmd;
    end else begin
      // RL11 error flag, no data
      if (illegalCmd || msgErrorDetect) begin
        messageErrorFlag <= 1'b1;
      end else if (cmdValid) begin
        messageErrorFlag <= 1'b0;
      end
      if (illegalCmd) begin
        dataWordsInhibit <= 1'b1;
      end else if (cmdValid) begin
        dataWordsInhibit <= 1'b0;
      end
    end
  end

  // ****************************************
  // Host serial frame check
  // ****************************************
  assign serEnd = hostSerialSelN & ~selPrev;
  // Frames must be whole bytes and not empty
  assign serBad = (serCount == {SER_CNT_W{1'b0}}) ||
    (serCount[2:0] != 3'h0);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selPrev <= 1'b1;
      sclkPrev <= 1'b0;
      serCount <= {SER_CNT_W{1'b0}};
      serFail <= 1'b0;
    end else begin
      selPrev <= hostSerialSelN;
      sclkPrev <= hostSerialClk;
      // RL12 wrong clock count
      serFail <= serEnd & serBad;
      if (hostSerialSelN) begin
        serCount <= {SER_CNT_W{1'b0}};
      end else if (hostSerialClk && !sclkPrev) begin
        // Saturate so a runaway frame still fails
        if (serCount != {SER_CNT_W{1'b1}}) begin
          serCount <= serCount + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Loopback compare
  // ****************************************
  assign lbMismatch = lbPending & rxWordValid & (rxWord != lbWord);
  // A new word before the echo counts as lost
  assign lbMissed = lbPending & txWordValid & ~rxWordValid;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lbPending <= 1'b0;
      lbBusB <= 1'b0;
      lbWord <= 16'h0000;
      lbFailA <= 1'b0;
      lbFailB <= 1'b0;
    end else begin
      // RL13 per bus mismatch
      lbFailA <= (lbMismatch | lbMissed) & ~lbBusB;
      lbFailB <= (lbMismatch | lbMissed) & lbBusB;
      if (txWordValid) begin
        lbPending <= 1'b1;
        lbBusB <= txBusB;
        lbWord <= txWord;
      end else if (rxWordValid) begin
        lbPending <= 1'b0;
      end
    end
  end

  // ****************************************
  // Time tag monitor
  // ****************************************
  // History dropped on soft reset, which clears the counter
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ttPrev <= `RTIE_TT_ZERO;
      ttSeen <= 1'b0;
      ttMatch <= 1'b0;
      ttWrap <= 1'b0;
    end else if (softResetCmd) begin
      ttPrev <= `RTIE_TT_ZERO;
      ttSeen <= 1'b0;
      ttMatch <= 1'b0;
      ttWrap <= 1'b0;
    end else begin
      ttPrev <= timeTagCount;
      ttSeen <= 1'b1;
      // RL14 count equals utility
      ttMatch <= ttSeen && (timeTagCount != ttPrev) &&
        (timeTagCount == timeTagUtility);
      // RL15 full count to zero
      ttWrap <= ttSeen && (ttPrev == `RTIE_TT_FULL) &&
        (timeTagCount == `RTIE_TT_ZERO);
    end
  end

  // ****************************************
  // Address parity monitor
  // ****************************************
  assign parNow = parityBad(termAddr, termAddrParity);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parPrev <= 1'b0;
      parFail <= 1'b0;
    end else begin
      parPrev <= parNow;
      // RL16 new parity error
      parFail <= parNow & (~parPrev | mrRise);
    end
  end

  // ****************************************
  // Event vector
  // ****************************************
  // RL6 index zero or circular count
  assign evtVec[`RTIE_B_IXZ] = indexDecToZero | circCountReached;
  // RL7 accessed subaddress
  assign evtVec[`RTIE_B_ACC] = msgAccess;
  // RL8 broadcast received
  assign evtVec[`RTIE_B_BCR] = msgAccess & msgBroadcast;
  assign evtVec[12] = 1'b0;
  assign evtVec[11] = 1'b0;
  // RL9 message error set
  assign evtVec[`RTIE_B_MSG_ERROR_IRQ] = msgErrorDetect;
  assign evtVec[9] = 1'b0;
  // RL10 illegal command event
  assign evtVec[`RTIE_B_ILL] = illegalCmd;
  assign evtVec[`RTIE_B_SER] = serFail;
  assign evtVec[`RTIE_B_LBA] = lbFailA;
  assign evtVec[`RTIE_B_LBB] = lbFailB;
  assign evtVec[`RTIE_B_TTM] = ttMatch;
  assign evtVec[`RTIE_B_TTW] = ttWrap;
  assign evtVec[`RTIE_B_PAR] = parFail;
  // RL17 checksum failure
  assign evtVec[`RTIE_B_CKS] = initChecksumFail;
  // RL18 RAM init mismatch
  assign evtVec[`RTIE_B_RAM] = ramInitFail;

  // RL19 descriptor bits per type
  assign descBits = {descIndexZeroEn, descAccessedEn, descBroadcastEn, 13'h0000};

  // ****************************************
  // Gating
  // ****************************************
  rtie_gate #(
    .W(16)
  ) uGate (
    .evt(evtVec),
    .descGated(`RTIE_DESC_MASK),
    .descBit(descBits),
    .enable(irqEnable),
    .pendSet(pendNow),
    .fire(fireNow)
  );

  assign anyMsgFire = |(fireNow & `RTIE_MSG_MASK);

  // ****************************************
  // Outputs and log
  // ****************************************
  // Outputs pulse one cycle per event cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      messageIrqOut <= 1'b0;
      hardwareIrqOut <= 1'b0;
      pendingSet <= 16'h0000;
      logWrite <= 1'b0;
      irqTypeWord <= 16'h0000;
      irqSourceWord <= 16'h0000;
    end else begin
      // RL4 gated outputs
      messageIrqOut <= anyMsgFire;
      hardwareIrqOut <= |(fireNow & `RTIE_HW_MASK);
      // RL21 pending set strobes
      pendingSet <= pendNow;
      logWrite <= |fireNow;
      if (|fireNow) begin
        // RL22 type and source words
        irqTypeWord <= fireNow;
        irqSourceWord <= anyMsgFire ? descAddr : `RTIE_HW_SRC;
      end
    end
  end

endmodule // rtie_top

`default_nettype wire

// >>> rtie_map.vh
// Offsets, field positions, reset values and masks of the interrupt enable block
`ifndef RTIE_MAP_VH
`define RTIE_MAP_VH

// ****************************************
// Register map
// ****************************************
`define RTIE_IE_OFS 16'h0010
`define RTIE_IE_RST 16'h0007
`define RTIE_IE_WMASK 16'he5f8
`define RTIE_IE_ROONE 16'h0007

// ****************************************
// Enable bit positions
// ****************************************
`define RTIE_B_IXZ 15
`define RTIE_B_ACC 14
`define RTIE_B_BCR 13
`define RTIE_B_MSG_ERROR_IRQ 10
`define RTIE_B_ILL 8
`define RTIE_B_SER 7
`define RTIE_B_LBA 6
`define RTIE_B_LBB 5
`define RTIE_B_TTM 4
`define RTIE_B_TTW 3
`define RTIE_B_PAR 2
`define RTIE_B_CKS 1
`define RTIE_B_RAM 0

// ****************************************
// Interrupt class masks
// ****************************************
`define RTIE_MSG_MASK 16'he560
`define RTIE_HW_MASK 16'h009f
`define RTIE_DESC_MASK 16'he000

// ****************************************
// Counter and log values
// ****************************************
`define RTIE_TT_FULL 16'hffff
`define RTIE_TT_ZERO 16'h0000
`define RTIE_HW_SRC 16'h0000
`define RTIE_SER_UNIT 8

`endif

// >>> rtie_gate.v
// Per-type gating of events by enable and descriptor bits
`default_nettype none

module rtie_gate #(
  parameter W = 16
) (
  input wire [W-1:0] evt,
  input wire [W-1:0] descGated,
  input wire [W-1:0] descBit,
  input wire [W-1:0] enable,
  output wire [W-1:0] pendSet,
  output wire [W-1:0] fire
);

  // ****************************************
  // Gating per type
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gGate
      wire descOk;
      // RL19 descriptor bit gate
      assign descOk = ~descGated[i] | descBit[i];
      // RL20 RL21 pending set
      assign pendSet[i] = evt[i] & descOk & (enable[i] | ~descGated[i]);
      // RL4 RL5 output only when enabled now
      assign fire[i] = evt[i] & descOk & enable[i];
    end
  endgenerate

endmodule // rtie_gate

`default_nettype wire

// >>> rtie_top_sva.sv
// Checker of the interrupt enable block outputs
`default_nettype none
module rtie_top_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] descAddr,
  input wire logic descAccessedEn,
  input wire logic msgAccess,
  input wire logic msgErrorDetect,
  input wire logic cmdValid,
  input wire logic illegalTableBit,
  input wire logic initChecksumFail,
  input wire logic ramInitFail,
  input wire logic [15:0] pendingSet,
  input wire logic messageIrqOut,
  input wire logic hardwareIrqOut,
  input wire logic [15:0] irqSourceWord,
  input wire logic messageErrorFlag,
  input wire logic dataWordsInhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Output relations
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_msg_error_irq_pends: assert property (
    msgErrorDetect |=> pendingSet[10] && messageErrorFlag) else $error("msg_error_irq not pended");
  a_illegal_reply: assert property (
    cmdValid && illegalTableBit |=> pendingSet[8] && messageErrorFlag && dataWordsInhibit)
    else $error("illegal command not answered");
  a_cks_fires: assert property (
    initChecksumFail |=> pendingSet[1] && hardwareIrqOut) else $error("checksum irq missing");
  a_ram_fires: assert property (
    ramInitFail |=> pendingSet[0] && hardwareIrqOut) else $error("ram init irq missing");
  a_desc_clear: assert property (
    msgAccess && !descAccessedEn |=> !pendingSet[14]) else $error("descriptor gate ignored");
  a_desc_out: assert property (
    |pendingSet[15:13] |-> messageIrqOut) else $error("descriptor type pended silently");
  a_hw_source: assert property (
    hardwareIrqOut && !messageIrqOut |-> irqSourceWord == 16'h0000) else $error("hw source");
  a_msg_source: assert property (
    msgAccess && descAccessedEn ##1 pendingSet[14] |-> irqSourceWord == $past(descAddr))
    else $error("message source word wrong");
endmodule // rtie_top_chk

bind rtie_top rtie_top_chk chk (.ref_clk, .rst, .descAddr, .descAccessedEn, .msgAccess,
  .msgErrorDetect, .cmdValid, .illegalTableBit, .initChecksumFail, .ramInitFail,
  .pendingSet, .messageIrqOut, .hardwareIrqOut, .irqSourceWord, .messageErrorFlag,
  .dataWordsInhibit);
`default_nettype wire

// >>> rtie_host_model.sv
// Host serial master model sending framed clock bursts
`default_nettype none
module rtie_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] nClk,
  output logic hostSerialSelN,
  output logic hostSerialClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] edgesLeft;
  // ****************************************
  // Frame engine
  // ****************************************
  // Clock stands low outside frames
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostSerialSelN <= 1'h1;
      hostSerialClk <= 1'h0;
      edgesLeft <= 9'h000;
    end else if (go && hostSerialSelN) begin
      hostSerialSelN <= 1'h0;
      edgesLeft <= {nClk, 1'h0};
    end else if (!hostSerialSelN) begin
      if (edgesLeft == 9'h000) begin
        hostSerialSelN <= 1'h1;
      end else begin
        hostSerialClk <= ~hostSerialClk;
        edgesLeft <= edgesLeft - 9'h001;
      end
    end
  end
endmodule // rtie_host_model
`default_nettype wire

// >>> test_rt_interrupt_enable_gating.sv
// Testbench of the interrupt enable block
`default_nettype none
module test_rt_interrupt_enable_gating;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = '0, rst = '1, masterResetN = '1, softResetCmd = '0, hostWrEn = '0;
  logic hostRdEn = '0, descIndexZeroEn = '0, descAccessedEn = '0, descBroadcastEn = '0;
  logic indexDecToZero = '0, circCountReached = '0, msgAccess = '0, msgBroadcast = '0;
  logic msgErrorDetect = '0, cmdValid = '0, illegalTableBit = '0, txWordValid = '0;
  logic txBusB = '0, rxWordValid = '0, termAddrParity = '1, initChecksumFail = '0;
  logic ramInitFail = '0, go = '0, hostSerialSelN, hostSerialClk;
  logic [15:0] hostAddr = '0, hostWrData = '0, descAddr = 16'h0123, txWord = '0, rxWord = '0;
  logic [15:0] timeTagCount = '0, timeTagUtility = 16'h0005;
  logic [15:0] hostRdData, pendingSet, irqTypeWord, irqSourceWord;
  logic [4:0] termAddr = '0;
  logic [7:0] nClk = '0;
  logic messageIrqOut, hardwareIrqOut, logWrite, messageErrorFlag, dataWordsInhibit;
  int fails = 0, checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  rtie_top dut (.ref_clk, .rst, .masterResetN, .softResetCmd, .hostAddr, .hostWrEn, .hostRdEn,
    .hostWrData, .hostRdData, .descAddr, .descIndexZeroEn, .descAccessedEn, .descBroadcastEn,
    .indexDecToZero, .circCountReached, .msgAccess, .msgBroadcast, .msgErrorDetect, .cmdValid,
    .illegalTableBit, .hostSerialSelN, .hostSerialClk, .txWordValid, .txBusB, .txWord,
    .rxWordValid, .rxWord, .timeTagCount, .timeTagUtility, .termAddr, .termAddrParity,
    .initChecksumFail, .ramInitFail, .messageIrqOut, .hardwareIrqOut, .pendingSet, .logWrite,
    .irqTypeWord, .irqSourceWord, .messageErrorFlag, .dataWordsInhibit);
  rtie_host_model host (.ref_clk, .rst, .go, .nClk, .hostSerialSelN, .hostSerialClk);

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(logic [15:0] a, logic [15:0] d);
    @(posedge ref_clk);
    hostAddr <= a;
    hostWrData <= d;
    hostWrEn <= 1'h1;
    @(posedge ref_clk);
    hostWrEn <= 1'h0;
  endtask
  task rd(logic [15:0] a, logic [15:0] exp);
    @(posedge ref_clk);
    hostAddr <= a;
    hostRdEn <= 1'h1;
    @(posedge ref_clk);
    hostRdEn <= 1'h0;
    @(posedge ref_clk);
    chk("enable read", exp, hostRdData);
  endtask
  // Bounded wait, a missed strobe costs 41 cycles
  task pend(int b, logic hw, logic expPend, logic expOut);
    logic sawOut;
    sawOut = 1'h0;
    @(negedge ref_clk);
    repeat (40) begin
      if (pendingSet[b] === 1'h1) break;
      sawOut = sawOut | ((hw ? hardwareIrqOut : messageIrqOut) === 1'h1);
      @(negedge ref_clk);
    end
    chk("pending strobe", 16'(expPend), 16'(pendingSet[b]));
    if (expPend) begin
      chk("irq output", 16'(expOut), 16'(hw ? hardwareIrqOut : messageIrqOut));
      chk("log write", 16'(expOut), 16'(logWrite));
      if (expOut) chk("type word bit", 16'h0001, 16'(irqTypeWord[b]));
    end else begin
      chk("stray output", 16'h0000, 16'(sawOut));
    end
    // Hand back on a rising edge so callers drive on it
    @(posedge ref_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_gate(logic [15:0] en, logic d);
    int bits[8] = '{15, 14, 13, 10, 8, 1, 0, 15};
    logic on;
    wr(16'h0010, en);
    {descIndexZeroEn, descAccessedEn, descBroadcastEn} <= {3{d}};
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      indexDecToZero <= (k == 0);
      msgAccess <= (k == 1 || k == 2);
      msgBroadcast <= (k == 2);
      msgErrorDetect <= (k == 3);
      {cmdValid, illegalTableBit} <= {2{k == 4}};
      initChecksumFail <= (k == 5);
      ramInitFail <= (k == 6);
      circCountReached <= (k == 7);
      @(posedge ref_clk);
      {indexDecToZero, msgAccess, msgErrorDetect, cmdValid, initChecksumFail} <= '0;
      {ramInitFail, circCountReached} <= '0;
      on = en[bits[k]] | (bits[k] < 3);
      pend(bits[k], bits[k] < 8, bits[k] < 13 || (d && on), on && (bits[k] < 13 || d));
      if (k == 1 && d && on) chk("message source", descAddr, irqSourceWord);
      if (k == 5) chk("hardware source", 16'h0000, irqSourceWord);
    end
  endtask
  task t_derived;
    nClk <= 8'h03;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    pend(7, 1'h1, 1'h1, 1'h1);
    nClk <= 8'h08;
    go <= 1'h1;
    @(posedge ref_clk);
    go <= 1'h0;
    pend(7, 1'h1, 1'h0, 1'h0);
    for (int b = 0; b < 2; b++) begin
      @(posedge ref_clk);
      {txWordValid, txBusB, txWord} <= {1'h1, b[0], 16'h1234};
      @(posedge ref_clk);
      {txWordValid, rxWordValid, rxWord} <= {2'h1, 16'h1235};
      @(posedge ref_clk);
      rxWordValid <= 1'h0;
      pend(6 - b, 1'h0, 1'h1, 1'h1);
    end
    timeTagCount <= 16'h0004;
    @(posedge ref_clk);
    timeTagCount <= 16'h0005;
    pend(4, 1'h1, 1'h1, 1'h1);
    timeTagCount <= 16'hffff;
    @(posedge ref_clk);
    timeTagCount <= 16'h0000;
    pend(3, 1'h1, 1'h1, 1'h1);
    termAddrParity <= 1'h0;
    pend(2, 1'h1, 1'h1, 1'h1);
  endtask

  initial begin
    #200us;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'h0;
    rd(16'h0010, 16'h0007);
    wr(16'h0010, 16'hffff);
    rd(16'h0010, 16'he5ff);
    wr(16'h0011, 16'h0000);
    rd(16'h0011, 16'h0000);
    rd(16'h0010, 16'he5ff);
    softResetCmd <= 1'h1;
    @(posedge ref_clk);
    softResetCmd <= 1'h0;
    rd(16'h0010, 16'he5ff);
    masterResetN <= 1'h0;
    wr(16'h0010, 16'he000);
    masterResetN <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rd(16'h0010, 16'h0007);
    t_gate(16'h0000, 1'h1);
    wr(16'h0010, 16'he5ff);
    pend(10, 1'h0, 1'h0, 1'h0);
    t_gate(16'he5ff, 1'h0);
    t_gate(16'he5ff, 1'h1);
    t_derived();
    tally_and_finish;
  end
endmodule // test_rt_interrupt_enable_gating
`default_nettype wire
